// *** verilog/ladm_monitor.sv ***
/*
  ladm_monitor: receive-side line AIS defect monitor with status, change
  interrupt and transmit RDI-L request.
  Assumes frame strobes, register strobes and defect levels are synchronous
  to core_clk; the transmit overhead inserter samples rdi_l_req.
*/
// How it works
// - The defect is declared after five consecutive frames whose k2 bits 6 to 8 are all ones.
// - A declared defect clears after five consecutive frames whose k2 bits 6 to 8 are not all ones.
// - Status bit 0 at 0x1106 reads one while the defect is declared and zero once cleared.
// - Declaring or clearing sets the change flag at bit 1 of the interrupt status at 0x1109.
// - A pending change flag, when enabled at bit 1 of the interrupt mask at 0x110a, drives the active-low interrupt request low.
// - With control bit 2 set and bits 0, 1 and 3 clear, RDI-L is requested for exactly as long as the defect stands.
`timescale 1ns/1ns
`default_nettype none
module ladm_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // received frame overhead
  input wire ladm_pkg::ladm_frame_t frame_in,
  // other defect sources for rdi-l
  input wire ladm_pkg::ladm_defect_t defect_in,
  // register port
  input wire ladm_pkg::ladm_reg_req_t reg_req,
  output logic [7:0] rd_data,
  // interrupt, transmit request and defect level
  output logic irq_n,
  output logic rdi_l_req,
  output logic ais_l_defect
);
  import ladm_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  ladm_state_t state_reg;
  ladm_state_t state_next;
  logic [2:0] run_reg;
  logic [2:0] run_next;
  logic [3:0] ctrl_reg;
  logic [7:0] int_mask_reg;
  logic [7:0] int_stat_reg;
  logic [7:0] int_stat_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic irq_n_reg;
  logic rdi_reg;
  logic rdi_next;

  // ************************************************************
  // frame decode
  // ************************************************************
  wire logic is_ais_frame;
  wire logic counts_toward_change;
  wire logic run_complete;
  wire logic change_evt;

  assign is_ais_frame = (frame_in.k2[2:0] == LADM_AIS_PATTERN);
  // a frame counts when it disagrees with the present state
  assign counts_toward_change = frame_in.valid &&
    (is_ais_frame == (state_reg == LADM_ST_CLEAR));
  assign run_complete = counts_toward_change && (run_reg == LADM_RUN_LAST);
  assign change_evt = run_complete;

  // ************************************************************
  // declare and clear state machine
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    run_next = run_reg;
    if (frame_in.valid)
    begin
      if (!counts_toward_change)
      begin
        // any agreeing frame breaks the run
        run_next = 3'h0;
      end
      else if (run_complete)
      begin
        run_next = 3'h0;
        unique case (state_reg)
          LADM_ST_CLEAR: state_next = LADM_ST_DECLARED;
          LADM_ST_DECLARED: state_next = LADM_ST_CLEAR;
        endcase
      end
      else
      begin
        run_next = run_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= LADM_ST_CLEAR;
      run_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      run_reg <= run_next;
    end
  end

  // ************************************************************
  // register decode
  // ************************************************************
  wire logic sel_status;
  wire logic sel_int_stat;
  wire logic sel_int_mask;
  wire logic sel_ctrl;
  wire logic [7:0] status_view;
  wire logic [7:0] int_stat_set;
  wire logic [7:0] int_stat_clr;
  wire logic [7:0] int_mask_next;

  assign sel_status = (reg_req.addr == LADM_ADDR_STATUS);
  assign sel_int_stat = (reg_req.addr == LADM_ADDR_INT_STATUS);
  assign sel_int_mask = (reg_req.addr == LADM_ADDR_INT_MASK);
  assign sel_ctrl = (reg_req.addr == LADM_ADDR_RDI_CTRL);

  assign status_view = {7'h00, (state_reg == LADM_ST_DECLARED)};

  assign int_stat_set = change_evt ? (8'h01 << LADM_INT_AIS_CHG_BIT) : 8'h00;
  assign int_stat_clr = (reg_req.rd && sel_int_stat) ? 8'hff :
    ((reg_req.wr && sel_int_stat) ? reg_req.wdata : 8'h00);

  // interrupt sees a mask write at once, so enabling a pending flag never lags
  assign int_mask_next = (reg_req.wr && sel_int_mask) ?
    (reg_req.wdata & (8'h01 << LADM_INT_AIS_CHG_BIT)) : int_mask_reg;

  // set beats clear so a change landing on the read is never lost
  assign int_stat_next = ((int_stat_reg & ~int_stat_clr) | int_stat_set) &
    (8'h01 << LADM_INT_AIS_CHG_BIT);

  always_comb
  begin
    rd_data_next = 8'h00;
    if (reg_req.rd)
    begin
      if (sel_status)
      begin
        rd_data_next = status_view;
      end
      else if (sel_int_stat)
      begin
        rd_data_next = int_stat_reg;
      end
      else if (sel_int_mask)
      begin
        rd_data_next = int_mask_reg;
      end
      else if (sel_ctrl)
      begin
        rd_data_next = {4'h0, ctrl_reg};
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_reg <= LADM_CTRL_RESET;
      int_mask_reg <= LADM_INT_MASK_RESET;
      int_stat_reg <= 8'h00;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      if (reg_req.wr && sel_ctrl)
      begin
        ctrl_reg <= reg_req.wdata[3:0] & LADM_CTRL_WMASK;
      end
      int_mask_reg <= int_mask_next;
      int_stat_reg <= int_stat_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ************************************************************
  // interrupt and rdi-l outputs
  // ************************************************************
  wire logic irq_pending;

  assign irq_pending = |(int_stat_next & int_mask_next);

  // follows the next state so rdi tracks the defect exactly
  always_comb
  begin
    rdi_next = (ctrl_reg[LADM_CTRL_RDI_AIS_BIT] && (state_next == LADM_ST_DECLARED)) ||
      (ctrl_reg[LADM_CTRL_RDI_LOS_BIT] && defect_in.los) ||
      (ctrl_reg[LADM_CTRL_RDI_LOF_BIT] && defect_in.lof) ||
      (ctrl_reg[LADM_CTRL_RDI_EXT_BIT] && defect_in.ext);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_n_reg <= 1'b1;
      rdi_reg <= 1'b0;
    end
    else
    begin
      irq_n_reg <= ~irq_pending;
      rdi_reg <= rdi_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign irq_n = irq_n_reg;
  assign rdi_l_req = rdi_reg;
  assign ais_l_defect = (state_reg == LADM_ST_DECLARED);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // consecutive ais and non-ais frames seen, kept apart from the design counters
  logic [3:0] chk_ais_run;
  logic [3:0] chk_clr_run;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      chk_ais_run <= 4'h0;
      chk_clr_run <= 4'h0;
    end
    else if (frame_in.valid)
    begin
      chk_ais_run <= is_ais_frame ? ((chk_ais_run == 4'hf) ? 4'hf : chk_ais_run + 4'h1) : 4'h0;
      chk_clr_run <= !is_ais_frame ? ((chk_clr_run == 4'hf) ? 4'hf : chk_clr_run + 4'h1) : 4'h0;
    end
  end

  sequence s_fifth_ais;
    frame_in.valid && is_ais_frame && (chk_ais_run >= 4'h4);
  endsequence

  sequence s_fifth_clear;
    frame_in.valid && !is_ais_frame && (chk_clr_run >= 4'h4);
  endsequence

  property p_declare;
    s_fifth_ais |=> ais_l_defect;
  endproperty
  a_declare: assert property (p_declare) else $error("ais-l not declared after five frames");

  property p_no_early_declare;
    !ais_l_defect ##1 ais_l_defect |-> $past(chk_ais_run) >= 4'h4;
  endproperty
  a_no_early_declare: assert property (p_no_early_declare) else $error("ais-l declared early");

  property p_clear;
    s_fifth_clear |=> !ais_l_defect;
  endproperty
  a_clear: assert property (p_clear) else $error("ais-l not cleared after five frames");

  property p_status_read;
    reg_req.rd && sel_status |=> rd_data[LADM_STATUS_AIS_BIT] == $past(ais_l_defect);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bit wrong");

  property p_change_flag;
    $changed(ais_l_defect) |-> int_stat_reg[LADM_INT_AIS_CHG_BIT];
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("change flag not set");

  property p_irq_low;
    int_stat_reg[LADM_INT_AIS_CHG_BIT] && int_mask_reg[LADM_INT_AIS_CHG_BIT] |-> !irq_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt not asserted");

  property p_rdi_follow;
    ctrl_reg[LADM_CTRL_RDI_AIS_BIT] && !(ctrl_reg[LADM_CTRL_RDI_LOS_BIT] ||
      ctrl_reg[LADM_CTRL_RDI_LOF_BIT] || ctrl_reg[LADM_CTRL_RDI_EXT_BIT])
      ##0 $stable(ctrl_reg) |-> rdi_l_req == ais_l_defect;
  endproperty
  a_rdi_follow: assert property (p_rdi_follow) else $error("rdi-l does not track ais-l");

  property p_read_clears;
    reg_req.rd && sel_int_stat && !change_evt |=> !int_stat_reg[LADM_INT_AIS_CHG_BIT] && irq_n;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear flag");

  sequence s_clear_edge;
    ais_l_defect ##1 !ais_l_defect;
  endsequence

  property p_no_early_clear;
    s_clear_edge |-> $past(chk_clr_run) >= 4'h4;
  endproperty
  a_no_early_clear: assert property (p_no_early_clear) else $error("ais-l cleared early");

  property p_frame_step;
    $changed(ais_l_defect) |-> $past(frame_in.valid);
  endproperty
  a_frame_step: assert property (p_frame_step) else $error("change without frame");

  property p_flag_rise;
    $rose(int_stat_reg[LADM_INT_AIS_CHG_BIT]) |-> $changed(ais_l_defect);
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without change");

  // sticky unless software touches the interrupt status register
  sequence s_flag_untouched;
    int_stat_reg[LADM_INT_AIS_CHG_BIT] && !(sel_int_stat && (reg_req.rd || reg_req.wr));
  endsequence

  property p_flag_sticky;
    s_flag_untouched |=> int_stat_reg[LADM_INT_AIS_CHG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_irq_release;
    !(int_stat_reg[LADM_INT_AIS_CHG_BIT] && int_mask_reg[LADM_INT_AIS_CHG_BIT]) |-> irq_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt stuck low");

  property p_rdi_quiet;
    (ctrl_reg == 4'h0) ##0 $stable(ctrl_reg) |-> !rdi_l_req;
  endproperty
  a_rdi_quiet: assert property (p_rdi_quiet) else $error("rdi-l without source");

  property p_status_pad;
    reg_req.rd && sel_status |=> rd_data[7:1] == 7'h00;
  endproperty
  a_status_pad: assert property (p_status_pad) else $error("status unused bits set");

endmodule
`default_nettype wire

// *** verilog/ladm_pkg.sv ***
/*
  ladm_pkg: constants and carrier types for the line AIS defect monitor.
  Assumes one 250 MHz core clock and a byte-wide register port.
*/
`default_nettype none
package ladm_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [15:0] LADM_ADDR_STATUS = 16'h1106;
  localparam logic [15:0] LADM_ADDR_INT_STATUS = 16'h1109;
  localparam logic [15:0] LADM_ADDR_INT_MASK = 16'h110a;
  localparam logic [15:0] LADM_ADDR_RDI_CTRL = 16'h1933;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int LADM_STATUS_AIS_BIT = 0;
  localparam int LADM_INT_AIS_CHG_BIT = 1;
  localparam int LADM_CTRL_RDI_LOS_BIT = 0;
  localparam int LADM_CTRL_RDI_LOF_BIT = 1;
  localparam int LADM_CTRL_RDI_AIS_BIT = 2;
  localparam int LADM_CTRL_RDI_EXT_BIT = 3;
  localparam logic [3:0] LADM_CTRL_WMASK = 4'hf;
  localparam logic [3:0] LADM_CTRL_RESET = 4'h0;
  localparam logic [7:0] LADM_INT_MASK_RESET = 8'h00;

  // ************************************************************
  // detection constants
  // ************************************************************
  // k2 bits 6..8 sit in byte bits 2..0 (bit 1 is the msb on the line)
  localparam logic [2:0] LADM_AIS_PATTERN = 3'h7;
  localparam logic [2:0] LADM_FRAMES_TO_ACT = 3'h5;
  localparam logic [2:0] LADM_RUN_LAST = 3'h4;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [7:0] k2;
  } ladm_frame_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ladm_reg_req_t;

  typedef struct packed {
    logic los;
    logic lof;
    logic ext;
  } ladm_defect_t;

  typedef enum logic {
    LADM_ST_CLEAR,
    LADM_ST_DECLARED
  } ladm_state_t;

endpackage
`default_nettype wire

// *** dv/ladm_far_end.sv ***
/*
  ladm_far_end: remote line terminal model, one k2 byte per frame.
  Assumes the bench holds send_en high for as long as it wants frames.
*/
`timescale 1ns/1ns
`default_nettype none
module ladm_far_end (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bench control
  input wire logic send_en,
  input wire logic [7:0] k2_val,
  // frame link
  output ladm_pkg::ladm_frame_t frame_out,
  output logic [7:0] sent
);
  import ladm_pkg::*;
  logic [1:0] slot_reg;
  wire emit = send_en && (slot_reg == 2'h0);
  // ************************************************************
  // one frame every four cycles
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      slot_reg <= 2'h0;
      sent <= 8'h00;
      frame_out <= '0;
    end
    else
    begin
      slot_reg <= slot_reg + 2'h1;
      frame_out.valid <= emit;
      // idle k2 toggles so no stale byte looks valid
      frame_out.k2 <= emit ? k2_val : ~frame_out.k2;
      sent <= sent + {7'h00, emit};
    end
  end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
/*
  tb: self-checking bench for ladm_monitor.
  Assumes the far-end model and the package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ladm_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic send_en = 1'b0;
  logic [7:0] k2_val = 8'h00;
  ladm_frame_t frame;
  ladm_defect_t defect_in = '0;
  ladm_reg_req_t reg_req = '0;
  logic [7:0] rd_data, sent, rv;
  logic irq_n, rdi_l_req, ais_l_defect;
  int mismatches = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  ladm_far_end ladm_far_end_inst (.core_clk(core_clk), .reset(reset), .send_en(send_en),
    .k2_val(k2_val), .frame_out(frame), .sent(sent));
  ladm_monitor ladm_monitor_inst (.core_clk(core_clk), .reset(reset), .frame_in(frame),
    .defect_in(defect_in), .reg_req(reg_req), .rd_data(rd_data), .irq_n(irq_n),
    .rdi_l_req(rdi_l_req), .ais_l_defect(ais_l_defect));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic frames(input int n, input logic [7:0] k);
    logic [7:0] target;
    int i;
    target = sent + 8'(n);
    @(posedge core_clk);
    k2_val <= k;
    send_en <= 1'b1;
    for (i = 0; i < 100 && sent != target; i++)
      @(posedge core_clk);
    if (sent != target)
    begin
      mismatches++;
      tally_and_finish();
    end
    send_en <= 1'b0;
    tick(3);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic sc_reset_map();
    logic [15:0] addrs [5];
    addrs = '{LADM_ADDR_STATUS, LADM_ADDR_INT_STATUS, LADM_ADDR_INT_MASK,
      LADM_ADDR_RDI_CTRL, 16'h1234};
    wr(LADM_ADDR_STATUS, 8'hff);
    wr(16'h1234, 8'hff);
    foreach (addrs[i])
    begin
      rd(addrs[i], rv);
      check(rv, 8'h00);
    end
    check({7'h00, irq_n}, 8'h01);
  endtask
  task automatic sc_declare();
    wr(LADM_ADDR_INT_MASK, 8'h02);
    wr(LADM_ADDR_RDI_CTRL, 8'h04);
    frames(4, 8'hff);
    frames(1, 8'hf6);
    frames(4, 8'h07);
    check({7'h00, ais_l_defect}, 8'h00);
    frames(1, 8'h0f);
    check({ais_l_defect, irq_n, rdi_l_req}, 8'h05);
    rd(LADM_ADDR_STATUS, rv);
    check(rv, 8'h01);
    rd(LADM_ADDR_INT_STATUS, rv);
    check(rv, 8'h02);
    tick(1);
    check({7'h00, irq_n}, 8'h01);
    rd(LADM_ADDR_INT_STATUS, rv);
    check(rv, 8'h00);
  endtask
  task automatic sc_clear();
    frames(2, 8'h00);
    frames(1, 8'h07);
    frames(4, 8'h05);
    check({ais_l_defect, rdi_l_req}, 8'h03);
    frames(1, 8'h01);
    check({ais_l_defect, irq_n, rdi_l_req}, 8'h00);
    rd(LADM_ADDR_STATUS, rv);
    check(rv, 8'h00);
    wr(LADM_ADDR_INT_STATUS, 8'h02);
    tick(1);
    check({7'h00, irq_n}, 8'h01);
  endtask
  task automatic sc_masked_sources();
    wr(LADM_ADDR_INT_MASK, 8'h00);
    wr(LADM_ADDR_RDI_CTRL, 8'h0b);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      defect_in <= ladm_defect_t'(3'h1 << i);
      tick(2);
      check({7'h00, rdi_l_req}, 8'h01);
    end
    @(posedge core_clk);
    defect_in <= '0;
    frames(5, 8'h07);
    check({ais_l_defect, irq_n, rdi_l_req}, 8'h06);
    wr(LADM_ADDR_INT_MASK, 8'h02);
    tick(1);
    check({7'h00, irq_n}, 8'h00);
    rd(LADM_ADDR_INT_STATUS, rv);
    check(rv, 8'h02);
    check({7'h00, irq_n}, 8'h01);
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    sc_reset_map();
    sc_declare();
    sc_clear();
    sc_masked_sources();
    tally_and_finish();
  end
endmodule
`default_nettype wire
